/* File: rtl/perfmon_irq_defs.svh */
/*
  Offsets, field positions, reset values and sizes for the
  performance event interrupt block.
  Assumes a byte-addressed APB register window with 32-bit words.
*/
`ifndef PERFMON_IRQ_DEFS_SVH
`define PERFMON_IRQ_DEFS_SVH

`define OFF_OVF_LOC       12'h318
`define OFF_CNT_LOC       12'h31C
`define OFF_FLAG          12'h324
`define OFF_CTRL          12'h328
`define OFF_PAYLOAD       12'h32C
`define OFF_TGT_LO        12'h330
`define OFF_TGT_HI        12'h334
`define OFF_SIG_MASK      12'h338
`define ADDR_BITS         12

`define CTRL_MASK_BIT     31
`define CTRL_HELD_BIT     30
`define CTRL_RSVD_RST     30'h0000000
`define OVF_ALIGN_BITS    3
`define NUM_COUNTERS      8
`define PAYLOAD_W         16

`endif

/* File: rtl/perfmon_irq_pkg.sv */
/*
  Types for the performance event interrupt block.
  Assumes perfmon_irq_defs.svh is compiled alongside.
*/
package perfmon_irq_pkg;

  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
    logic [31:0] data;
  } msg_type;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_SEND = 2'b01
  } msg_state_type;

  typedef struct packed {
    logic          flag;
    logic          maskBit;
    logic          held;
    logic [29:0]   ctrlRsvd;
    logic [15:0]   payload;
    logic [29:0]   tgtLo;
    logic [31:0]   tgtHi;
    logic          sigMask;
    logic          sent;
    msg_state_type mstate;
    msg_type       msg;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
  } state_type;

endpackage

/* File: rtl/perfmon_irq.sv */
/*
  Performance event interrupt block: location registers, event flag,
  message mask and pending logic, and message emission.
  Assumes counter overflow and interrupt-enable vectors arrive in the
  clk domain, and that the fabric accepts a message with msgReady.
*/
`timescale 1ns/1ns
`include "perfmon_irq_defs.svh"

module perfmon_irq (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`ADDR_BITS-1:0]      paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Configuration from neighbouring logic
  input  wire logic                       perfmonSupported,
  input  wire logic [31:0]                overflowLocation,
  input  wire logic [31:0]                counterLocation,
  input  wire logic [4:0]                 strideBits,
  // Counter events
  input  wire logic [`NUM_COUNTERS-1:0]   counterOverflow,
  input  wire logic [`NUM_COUNTERS-1:0]   irqOnOverflow,
  // Message to fabric
  output perfmon_irq_pkg::msg_type        msgOut,
  input  wire logic                       msgReady,
  // Local interrupt
  output logic                            irq
);
  import perfmon_irq_pkg::*;

  state_type s_q;
  state_type s_d;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] lowZero(input logic [31:0] v,
                                          input logic [5:0]  n);
    logic [31:0] m;
    m = 32'hFFFFFFFF << n;
    return v & m;
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  logic        access;
  logic        wr;
  logic        event1;
  logic        flagClr;
  logic [31:0] ctrlWord;
  logic [31:0] ctrlNew;
  logic [31:0] wv;
  logic [31:0] rd;
  logic        hit;

  always_comb begin
    s_d      = s_q;
    access   = psel && penable && !s_q.pready;
    wr       = access && pwrite && perfmonSupported;
    ctrlWord = {s_q.maskBit, s_q.held, s_q.ctrlRsvd};
    ctrlNew  = ctrlWord;
    wv       = 32'h00000000;
    rd       = 32'h00000000;
    hit      = 1'b1;
    flagClr  = 1'b0;
    event1   = perfmonSupported && |(counterOverflow & irqOnOverflow);

    s_d.pready  = access;
    s_d.pslverr = 1'b0;

    // Register writes
    if (wr) begin
      unique case (paddr)
        `OFF_FLAG: begin
          wv      = laneMerge(32'h00000000, pwdata, pstrb);
          flagClr = wv[0];
        end
        `OFF_CTRL: begin
          ctrlNew = laneMerge(ctrlWord, pwdata, pstrb);
          s_d.maskBit  = ctrlNew[`CTRL_MASK_BIT];
          s_d.ctrlRsvd = ctrlNew[29:0];
        end
        `OFF_PAYLOAD: begin
          wv = laneMerge({16'h0000, s_q.payload}, pwdata, pstrb);
          s_d.payload = wv[15:0];
        end
        `OFF_TGT_LO: begin
          wv = laneMerge({s_q.tgtLo, 2'b00}, pwdata, pstrb);
          s_d.tgtLo = wv[31:2];
        end
        `OFF_TGT_HI: begin
          s_d.tgtHi = laneMerge(s_q.tgtHi, pwdata, pstrb);
        end
        `OFF_SIG_MASK: begin
          wv = laneMerge({31'h0, s_q.sigMask}, pwdata, pstrb);
          s_d.sigMask = wv[0];
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end

    // Event flag: set wins over clear
    if (flagClr) begin
      s_d.flag = 1'b0;
      s_d.sent = 1'b0;
      s_d.held = 1'b0;
    end
    if (event1) begin
      s_d.flag = 1'b1;
    end

    // Message generation, one per flag assertion
    if (event1 && !s_q.flag && !s_q.sent && s_q.mstate == MS_IDLE) begin
      if (s_d.maskBit) begin
        s_d.held = 1'b1;
      end else begin
        s_d.mstate = MS_SEND;
        s_d.sent   = 1'b1;
      end
    end else if (s_q.held && !s_d.maskBit && !flagClr &&
                 s_q.mstate == MS_IDLE) begin
      s_d.mstate = MS_SEND;
      s_d.held   = 1'b0;
      s_d.sent   = 1'b1;
    end

    // Message port
    unique case (s_q.mstate)
      MS_IDLE: begin
        s_d.msg.valid = 1'b0;
        if (s_d.mstate == MS_SEND) begin
          s_d.msg.valid = 1'b1;
          s_d.msg.addr  = {s_q.tgtHi, s_q.tgtLo, 2'b00};
          s_d.msg.data  = {16'h0000, s_q.payload};
        end
      end
      MS_SEND: begin
        if (msgReady) begin
          s_d.msg.valid = 1'b0;
          s_d.mstate    = MS_IDLE;
        end
      end
      default: begin
        s_d.mstate = MS_IDLE;
      end
    endcase
    // Mask set while queued: withdraw and hold instead
    // Held only while the flag stands, so a cleared flag drops it
    if (s_q.mstate == MS_SEND && !msgReady && s_d.maskBit) begin
      s_d.msg.valid = 1'b0;
      s_d.mstate    = MS_IDLE;
      s_d.held      = s_d.flag;
    end

    // Register reads
    unique case (paddr)
      `OFF_OVF_LOC:  rd = lowZero(overflowLocation,
                                  6'(`OVF_ALIGN_BITS));
      `OFF_CNT_LOC:  rd = lowZero(counterLocation, {1'b0, strideBits});
      `OFF_FLAG:     rd = {31'h0, s_q.flag};
      `OFF_CTRL:     rd = {s_q.maskBit, s_q.held, s_q.ctrlRsvd};
      `OFF_PAYLOAD:  rd = {16'h0000, s_q.payload};
      `OFF_TGT_LO:   rd = {s_q.tgtLo, 2'b00};
      `OFF_TGT_HI:   rd = s_q.tgtHi;
      `OFF_SIG_MASK: rd = {31'h0, s_q.sigMask};
      default: begin
        rd  = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    if (!perfmonSupported) begin
      rd = 32'h00000000;
    end
    if (access) begin
      s_d.prdata  = pwrite ? 32'h00000000 : rd;
      s_d.pslverr = !hit;
    end

    s_d.irq = s_d.flag && s_d.sigMask;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q          <= '0;
      // Mask leaves reset set
      s_q.maskBit  <= 1'b1;
      s_q.ctrlRsvd <= `CTRL_RSVD_RST;
      s_q.mstate   <= MS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign msgOut  = s_q.msg;
  assign irq     = s_q.irq;

  // ==========================================================
  // Checks
  // ==========================================================
  // Bus-side write strobes for the checks below
  logic wrFlag1;
  logic wrCtrl;
  assign wrFlag1 = psel && penable && pwrite && !s_q.pready &&
                   paddr == `OFF_FLAG && pstrb[0] && pwdata[0] &&
                   perfmonSupported;
  assign wrCtrl  = psel && penable && pwrite && !s_q.pready &&
                   paddr == `OFF_CTRL && perfmonSupported;

  property p_ovf;
    @(posedge clk) disable iff (sys_rst)
    s_q.pready && !pwrite && paddr == `OFF_OVF_LOC |->
      prdata[2:0] == 3'h0;
  endproperty
  ovf_low_zero_a: assert property (p_ovf) else $error("ovf low bits");

  cnt_low_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pready) && !pwrite && paddr == `OFF_CNT_LOC |->
      (prdata & ~(32'hFFFFFFFF << strideBits)) == 32'h0)
    else $error("counter offset low bits");

  unsup_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    pready && !perfmonSupported && !$past(perfmonSupported) |->
      prdata == 32'h0)
    else $error("unsupported read nonzero");

  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    event1 |=> s_q.flag)
    else $error("flag not set");

  send_unmasked_a: assert property (@(posedge clk) disable iff (sys_rst)
    event1 && !s_q.flag && !s_q.sent && !s_q.maskBit && !wrCtrl &&
    s_q.mstate == MS_IDLE |=> msgOut.valid)
    else $error("message not sent");

  mask_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(msgOut.valid) |-> !s_q.maskBit)
    else $error("message while masked");

  held_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    event1 && !s_q.flag && !s_q.sent && s_q.maskBit && !wrCtrl &&
    s_q.mstate == MS_IDLE |=> s_q.held)
    else $error("pending not set");

  unmask_send_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrCtrl && pstrb[3] && !pwdata[`CTRL_MASK_BIT] && s_q.held &&
    s_q.mstate == MS_IDLE
      |=> msgOut.valid && !s_q.held)
    else $error("held message lost");

  clear_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrFlag1 && !event1 |=> !s_q.held && !$rose(msgOut.valid))
    else $error("pending survived clear");

  msg_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    msgOut.valid |-> msgOut.addr[1:0] == 2'b00 && msgOut.data[31:16] == 16'h0)
    else $error("message format");

  one_msg_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(msgOut.valid) && s_q.flag && !s_q.held && !wrFlag1
      |=> !msgOut.valid)
    else $error("second message");

  // Pending, flag and register-write bookkeeping
  flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrFlag1 && !event1 |=> !s_q.flag)
    else $error("flag not cleared");

  held_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(s_q.held) |-> msgOut.valid || $past(wrFlag1))
    else $error("pending dropped without cause");

  held_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.held |-> s_q.flag)
    else $error("pending without flag");

  msg_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(msgOut.valid) |-> s_q.flag)
    else $error("message without event");

  rsvd_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wrCtrl |=> $stable(s_q.ctrlRsvd))
    else $error("reserved control bits changed");

  unsup_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    access && pwrite && !perfmonSupported |=>
      $stable(s_q.payload) && $stable(s_q.tgtHi) && $stable(s_q.ctrlRsvd))
    else $error("write taken while unsupported");

  // Register read format
  payload_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.pready && !pwrite && paddr == `OFF_PAYLOAD |->
      prdata[31:16] == 16'h0000)
    else $error("payload upper bits");

  flag_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.pready && !pwrite && paddr == `OFF_FLAG |->
      prdata[31:1] == 31'h0)
    else $error("status upper bits");

  addr_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.pready && !pwrite && paddr == `OFF_TGT_LO |->
      prdata[1:0] == 2'b00)
    else $error("target low bits");

  // Main scenarios
  cover_send_c:   cover property (@(posedge clk) $rose(msgOut.valid));
  cover_held_c:   cover property (@(posedge clk) $rose(s_q.held));
  cover_unmask_c: cover property (@(posedge clk)
    s_q.held ##1 !s_q.held && msgOut.valid);
  cover_clear_c:  cover property (@(posedge clk) s_q.held && wrFlag1);
  cover_unsup_c:  cover property (@(posedge clk) access && !perfmonSupported);

endmodule

/* File: testbench/msg_sink.sv */
/*
  Fabric model that takes interrupt messages from the block.
  Assumes valid holds until accepted; delay sets the stall before ready.
*/
`timescale 1ns/1ns

module msg_sink (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sysRst,
  // Message port
  input  perfmon_irq_pkg::msg_type msgIn,
  input  wire logic [3:0]         delay,
  output logic                    msgReady,
  // Record of accepted messages
  output perfmon_irq_pkg::msg_type lastMsg,
  output logic [7:0]              gotCount
);
  import perfmon_irq_pkg::*;
  logic [3:0] waitCnt;
  // ==========================================
  // Accept after a programmable stall
  always_ff @(posedge clk) begin
    if (sysRst) begin
      msgReady <= 1'b0;
      waitCnt  <= 4'h0;
      gotCount <= 8'h00;
      lastMsg  <= '0;
    end else if (!msgIn.valid) begin
      msgReady <= 1'b0;
      waitCnt  <= 4'h0;
    end else if (msgReady) begin
      gotCount <= gotCount + 8'h01;
      lastMsg  <= msgIn;
      msgReady <= 1'b0;
      waitCnt  <= 4'h0;
    end else if (waitCnt >= delay) begin
      msgReady <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

/* File: testbench/tb_perfmon_irq.sv */
/*
  Self-checking bench for perfmon_irq over APB with a fabric model.
  Assumes the defs header is on the include path.
*/
`timescale 1ns/1ns
`include "perfmon_irq_defs.svh"

module tb_perfmon_irq;
  import perfmon_irq_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, delay;
  logic        perfmonSupported, msgReady;
  logic [7:0]  ov, en, gotCount;
  msg_type     msgOut, lastMsg;
  int          fails, comparisons;

  perfmon_irq dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .perfmonSupported(perfmonSupported), .overflowLocation(32'h00001237),
    .counterLocation(32'h00041FFF), .strideBits(5'h0C),
    .counterOverflow(ov), .irqOnOverflow(en), .msgOut(msgOut),
    .msgReady(msgReady), .irq(irq));
  msg_sink sink_u (.clk(clk), .sysRst(sys_rst), .msgIn(msgOut),
    .delay(delay), .msgReady(msgReady), .lastMsg(lastMsg),
    .gotCount(gotCount));

  // ==========================================
  // Shared tasks
  task final_report;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask
  task fire(input logic [7:0] o, input logic [7:0] e);
    ov <= o;
    en <= e;
    @(posedge clk);
    ov <= 8'h00;
    @(posedge clk);
  endtask
  task waitmsg(input logic [7:0] exp);
    int n;
    for (n = 0; n < 40 && gotCount !== exp; n++) @(posedge clk);
    check({24'h0, gotCount}, {24'h0, exp});
  endtask

  // ==========================================
  // Scenarios
  task t_reset;
    logic [31:0] r;
    logic e;
    rdchk(`OFF_CTRL, 32'h80000000);
    rdchk(`OFF_FLAG, 32'h0);
    rdchk(`OFF_PAYLOAD, 32'h0);
    rdchk(`OFF_OVF_LOC, 32'h00001230);
    rdchk(`OFF_CNT_LOC, 32'h00041000);
    apb(1'b0, 12'h300, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    wr(`OFF_OVF_LOC, 32'hFFFFFFFF);
    rdchk(`OFF_OVF_LOC, 32'h00001230);
  endtask
  task t_unmasked;
    delay <= 4'h5;
    wr(`OFF_PAYLOAD, 32'hABCD5A5A);
    rdchk(`OFF_PAYLOAD, 32'h00005A5A);
    wr(`OFF_TGT_LO, 32'hFEE01007);
    wr(`OFF_TGT_HI, 32'h12345678);
    wr(`OFF_CTRL, 32'h00001234);
    rdchk(`OFF_CTRL, 32'h00001234);
    fire(8'h01, 8'h02);
    rdchk(`OFF_FLAG, 32'h0);
    fire(8'h06, 8'h02);
    waitmsg(8'h01);
    check(lastMsg.addr[31:0], 32'hFEE01004);
    check(lastMsg.addr[63:32], 32'h12345678);
    check(lastMsg.data, 32'h00005A5A);
    rdchk(`OFF_FLAG, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(`OFF_SIG_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    fire(8'h02, 8'h02);
    waitmsg(8'h01);
    wr(`OFF_FLAG, 32'h1);
    rdchk(`OFF_FLAG, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask
  task t_masked;
    delay <= 4'h0;
    wr(`OFF_CTRL, 32'h80000000);
    fire(8'h80, 8'h80);
    rdchk(`OFF_CTRL, 32'hC0000000);
    waitmsg(8'h01);
    wr(`OFF_CTRL, 32'h0);
    waitmsg(8'h02);
    rdchk(`OFF_CTRL, 32'h0);
    wr(`OFF_FLAG, 32'h1);
  endtask
  task t_drop;
    wr(`OFF_CTRL, 32'h80000000);
    fire(8'h10, 8'h10);
    wr(`OFF_FLAG, 32'h1);
    rdchk(`OFF_CTRL, 32'h80000000);
    wr(`OFF_CTRL, 32'h0);
    waitmsg(8'h02);
  endtask
  task t_unsup;
    perfmonSupported <= 1'b0;
    @(posedge clk);
    rdchk(`OFF_OVF_LOC, 32'h0);
    rdchk(`OFF_CTRL, 32'h0);
    wr(`OFF_PAYLOAD, 32'h0000FFFF);
    perfmonSupported <= 1'b1;
    @(posedge clk);
    rdchk(`OFF_PAYLOAD, 32'h00005A5A);
  endtask

  // ==========================================
  // Clock, reset, run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    delay = 4'h0;
    perfmonSupported = 1'b1;
    ov = 8'h00;
    en = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_unmasked();
    t_masked();
    t_drop();
    t_unsup();
    final_report();
  end
endmodule
